// ### verilog/color_acq_params.svh
/*
  Constants for the colour sensor acquisition register bank: register
  offsets, bit positions, reset values and timing figures.
  Assumes inclusion by bare name from the design files.
*/
`ifndef COLOR_ACQ_PARAMS_SVH
`define COLOR_ACQ_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define ADDR_INTEG_TIME      8'hd9
`define ADDR_PAUSE_TIME      8'hda
`define ADDR_BANK_SELECT     8'hdb
`define ADDR_N_LOW           8'hdc
`define ADDR_N_HIGH          8'hdd
`define ADDR_Y_LOW           8'hde
`define ADDR_Y_HIGH          8'hdf
`define ADDR_Z_LOW           8'hec
`define ADDR_Z_HIGH          8'hed
`define ADDR_X_LOW           8'hee
`define ADDR_X_HIGH          8'hef
`define ADDR_ACQ_CONTROL     8'hfa

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_LATCH            7
`define BIT_WAIT_EN          3
`define BIT_ACQ_EN           1
`define BIT_POWER            0
`define BIT_BANK             7

// ****************************************************************
// reset values
// ****************************************************************
`define RST_INTEG_TIME       8'hff
`define RST_PAUSE_TIME       8'hff
`define RST_CTRL_BIT         1'b0
`define RST_BANK             1'b0
`define RST_RESULT           16'h0000
`define RST_RDATA            8'h00
`define READ_UNMAPPED        8'h00

// ****************************************************************
// timing
// ****************************************************************
`define UNIT_TIME_NS         2800000
`define CLK_PERIOD_NS        50
`define UNIT_CYCLES          (`UNIT_TIME_NS / `CLK_PERIOD_NS)
`define STEP_BASE            9'h100

`endif

// ### verilog/color_acq_pkg.sv
/*
  Types shared by the acquisition register bank and its step timer.
  Assumes the params header is compiled alongside.
*/
`default_nettype none
package color_acq_pkg;

  // one set of four channel results
  typedef struct packed {
    logic [15:0] n;
    logic [15:0] y;
    logic [15:0] z;
    logic [15:0] x;
  } result_set_s;

  // host-visible control bits of the acquisition control register
  typedef struct packed {
    logic latch;
    logic wait_en;
    logic acq_en;
    logic power;
  } acq_ctrl_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_INTEG = 3'b010,
    ST_PAUSE = 3'b100
  } acq_state_e;

endpackage
`default_nettype wire

// ### verilog/step_timer.sv
/*
  Counts a number of 2.8 ms steps and pulses done on the last cycle.
  Assumes start is a one-cycle pulse from the sequencer on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "color_acq_params.svh"
module step_timer
  import color_acq_pkg::*;
#(
  parameter int UNIT_CYC = `UNIT_CYCLES
) (
  input  wire logic       mclk,     // system clock
  input  wire logic       nrst,     // async reset, active low
  input  wire logic       start,    // load and begin counting
  input  wire logic       abort,    // stop counting
  input  wire logic [8:0] steps,    // number of steps, 1..256
  output logic            busy,     // counting
  output logic            done      // last cycle of the interval
);

  logic [31:0] sub_r;
  logic [31:0] sub_nxt;
  logic [8:0]  rem_r;
  logic [8:0]  rem_nxt;
  logic        busy_r;
  logic        busy_nxt;
  logic        last_sub;

  assign last_sub = (sub_r == 32'(UNIT_CYC - 1));
  assign busy     = busy_r;
  assign done     = busy_r && last_sub && (rem_r == 9'h001);

  always_comb begin
    sub_nxt  = sub_r;
    rem_nxt  = rem_r;
    busy_nxt = busy_r;
    if (abort) begin
      busy_nxt = 1'b0;
      sub_nxt  = 32'h0000_0000;
    end else if (start) begin
      busy_nxt = 1'b1;
      sub_nxt  = 32'h0000_0000;
      rem_nxt  = steps;
    end else if (busy_r) begin
      if (last_sub) begin
        sub_nxt = 32'h0000_0000;
        rem_nxt = rem_r - 9'h001;
        if (rem_r == 9'h001) begin
          busy_nxt = 1'b0;
        end
      end else begin
        sub_nxt = sub_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sub_r  <= 32'h0000_0000;
      rem_r  <= 9'h000;
      busy_r <= 1'b0;
    end else begin
      sub_r  <= sub_nxt;
      rem_r  <= rem_nxt;
      busy_r <= busy_nxt;
    end
  end

endmodule
`default_nettype wire

// ### verilog/color_sensor_acquisition_regs.sv
/*
  Acquisition control and result registers of the colour sensor, with the
  integration / pause sequencer. Registers are reached through the
  register port of the two-wire slave; the analog front end delivers
  the four converted results on the same clock.
*/
// Function
// - The pause register is 8 bits, resets to 0xFF, and the pause lasts (256 - value) x 2.8 ms.
// - The pause is inserted between acquisitions only while the wait-enable bit 3 is set.
// - Acquisitions run only while acquisition-enable bit 1 is set; bit and register reset to 0.
// - With latch bit 7 set, results are copied into the readable registers when an acquisition ends.
// - Channel N reads as low byte 0xDC and high 0xDD, Y as low 0xDE and high 0xDF, read only.
// - Z reads as low byte 0xEC and high 0xED, X as low 0xEE and high 0xEF, read only.
// - Integration lasts (256 - value) x 2.8 ms, value at 0xD9 resetting to 0xFF.
// - Bank bit 7 at 0xDB picks the channel set routed to the results, 1 meaning X, Y, Z and NIR.
`timescale 1ns/1ps
`default_nettype none
`include "color_acq_params.svh"
module color_sensor_acquisition_regs
  import color_acq_pkg::*;
#(
  parameter int UNIT_CYC = `UNIT_CYCLES
) (
  input  wire logic        mclk,         // system clock, 20 MHz
  input  wire logic        nrst,         // async reset, active low
  input  wire logic [7:0]  reg_addr,     // register offset
  input  wire logic [7:0]  reg_wdata,    // write data
  input  wire logic        reg_wr,       // write strobe, one cycle
  input  wire logic        reg_rd,       // read strobe, one cycle
  output logic      [7:0]  reg_rdata,    // read data, next cycle
  output logic             reg_rvalid,   // read data valid pulse
  input  wire result_set_s afe_result,   // live converted results
  output logic             bank_mode,    // channel set to front end
  output logic             power_on,     // power bit to analog
  output logic             integrating,  // integration in progress
  output logic             acq_done      // acquisition end pulse
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]  integ_time_r;
  logic [7:0]  integ_time_nxt;
  logic [7:0]  pause_time_r;
  logic [7:0]  pause_time_nxt;
  logic        bank_r;
  logic        bank_nxt;
  acq_ctrl_s   ctrl_r;
  acq_ctrl_s   ctrl_nxt;
  result_set_s result_r;
  result_set_s result_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  acq_state_e  state_r;
  acq_state_e  state_nxt;
  logic        tmr_start;
  logic        tmr_abort;
  logic [8:0]  tmr_steps;
  logic        tmr_busy;
  logic        tmr_done;
  logic        integ_end;

  // ****************************************************************
  // register writes
  // ****************************************************************
  always_comb begin
    integ_time_nxt = integ_time_r;
    pause_time_nxt = pause_time_r;
    bank_nxt       = bank_r;
    ctrl_nxt       = ctrl_r;
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_INTEG_TIME:  integ_time_nxt = reg_wdata;
        `ADDR_PAUSE_TIME:  pause_time_nxt = reg_wdata;
        `ADDR_BANK_SELECT: bank_nxt = reg_wdata[`BIT_BANK];
        `ADDR_ACQ_CONTROL: begin
          // reserved bits are dropped and read back as zero
          ctrl_nxt.latch   = reg_wdata[`BIT_LATCH];
          ctrl_nxt.wait_en = reg_wdata[`BIT_WAIT_EN];
          ctrl_nxt.acq_en  = reg_wdata[`BIT_ACQ_EN];
          ctrl_nxt.power   = reg_wdata[`BIT_POWER];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      integ_time_r <= `RST_INTEG_TIME;
      pause_time_r <= `RST_PAUSE_TIME;
      bank_r       <= `RST_BANK;
      ctrl_r       <= '{`RST_CTRL_BIT, `RST_CTRL_BIT, `RST_CTRL_BIT, `RST_CTRL_BIT};
    end else begin
      integ_time_r <= integ_time_nxt;
      pause_time_r <= pause_time_nxt;
      bank_r       <= bank_nxt;
      ctrl_r       <= ctrl_nxt;
    end
  end

  assign bank_mode = bank_r;
  assign power_on  = ctrl_r.power;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  assign integ_end = (state_r == ST_INTEG) && tmr_done;

  always_comb begin
    state_nxt = state_r;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    tmr_steps = `STEP_BASE - {1'b0, integ_time_r};
    if (!ctrl_r.acq_en) begin
      state_nxt = ST_IDLE;
      tmr_abort = 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          tmr_start = 1'b1;
          state_nxt = ST_INTEG;
        end
        ST_INTEG: begin
          if (tmr_done) begin
            tmr_start = 1'b1;
            if (ctrl_r.wait_en) begin
              tmr_steps = `STEP_BASE - {1'b0, pause_time_r};
              state_nxt = ST_PAUSE;
            end else begin
              state_nxt = ST_INTEG;
            end
          end
        end
        ST_PAUSE: begin
          if (tmr_done) begin
            tmr_start = 1'b1;
            state_nxt = ST_INTEG;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  step_timer #(
    .UNIT_CYC (UNIT_CYC)
  ) u_timer (
    .mclk  (mclk),
    .nrst  (nrst),
    .start (tmr_start),
    .abort (tmr_abort),
    .steps (tmr_steps),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  assign integrating = (state_r == ST_INTEG);
  assign acq_done    = integ_end;

  // ****************************************************************
  // results: held at acquisition end when latched, else live
  // ****************************************************************
  always_comb begin
    result_nxt = result_r;
    if (!ctrl_r.latch || integ_end) begin
      result_nxt = afe_result;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      result_r <= '{`RST_RESULT, `RST_RESULT, `RST_RESULT, `RST_RESULT};
    end else begin
      result_r <= result_nxt;
    end
  end

  // ****************************************************************
  // register reads
  // ****************************************************************
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_INTEG_TIME:  rdata_nxt = integ_time_r;
        `ADDR_PAUSE_TIME:  rdata_nxt = pause_time_r;
        `ADDR_BANK_SELECT: rdata_nxt = {bank_r, 7'h00};
        `ADDR_ACQ_CONTROL: rdata_nxt = {ctrl_r.latch, 3'h0, ctrl_r.wait_en, 1'b0, ctrl_r.acq_en, ctrl_r.power};
        `ADDR_N_LOW:       rdata_nxt = result_r.n[7:0];
        `ADDR_N_HIGH:      rdata_nxt = result_r.n[15:8];
        `ADDR_Y_LOW:       rdata_nxt = result_r.y[7:0];
        `ADDR_Y_HIGH:      rdata_nxt = result_r.y[15:8];
        `ADDR_Z_LOW:       rdata_nxt = result_r.z[7:0];
        `ADDR_Z_HIGH:      rdata_nxt = result_r.z[15:8];
        `ADDR_X_LOW:       rdata_nxt = result_r.x[7:0];
        `ADDR_X_HIGH:      rdata_nxt = result_r.x[15:8];
        default:           rdata_nxt = `READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_r  <= `RST_RDATA;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata  = rdata_r;
  assign reg_rvalid = rvalid_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [31:0] phase_cyc_r;
  logic [31:0] phase_cyc_nxt;
  logic [8:0]  phase_steps_r;
  logic [8:0]  phase_steps_nxt;

  // cycles spent in the current timed phase
  always_comb begin
    phase_cyc_nxt   = phase_cyc_r + 32'h0000_0001;
    phase_steps_nxt = phase_steps_r;
    if (tmr_start) begin
      phase_cyc_nxt   = 32'h0000_0000;
      phase_steps_nxt = tmr_steps;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phase_cyc_r   <= 32'h0000_0000;
      phase_steps_r <= 9'h000;
    end else begin
      phase_cyc_r   <= phase_cyc_nxt;
      phase_steps_r <= phase_steps_nxt;
    end
  end

  sequence s_integ_ends_waiting;
    integ_end && ctrl_r.wait_en && ctrl_r.acq_en;
  endsequence

  sequence s_integ_ends_direct;
    integ_end && !ctrl_r.wait_en && ctrl_r.acq_en;
  endsequence

  a_pause_write: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && reg_addr == `ADDR_PAUSE_TIME |=> pause_time_r == $past(reg_wdata))
    else $error("pause register not written");

  a_pause_length: assert property (@(posedge mclk) disable iff (!nrst)
    state_r == ST_PAUSE && tmr_done |->
      phase_cyc_r + 32'h0000_0001 == 32'(phase_steps_r) * 32'(UNIT_CYC))
    else $error("pause length wrong");

  a_pause_taken: assert property (@(posedge mclk) disable iff (!nrst)
    s_integ_ends_waiting |=> state_r == ST_PAUSE ##1 (state_r == ST_PAUSE || !$past(ctrl_r.acq_en)))
    else $error("pause not entered");

  a_pause_skipped: assert property (@(posedge mclk) disable iff (!nrst)
    s_integ_ends_direct |=> state_r == ST_INTEG && tmr_busy)
    else $error("next integration not started");

  a_acq_disabled: assert property (@(posedge mclk) disable iff (!nrst)
    !ctrl_r.acq_en |=> state_r == ST_IDLE && !tmr_busy)
    else $error("acquisition ran while disabled");

  a_latch_hold: assert property (@(posedge mclk) disable iff (!nrst)
    ctrl_r.latch && !integ_end |=> result_r == $past(result_r))
    else $error("latched results changed");

  a_latch_capture: assert property (@(posedge mclk) disable iff (!nrst)
    integ_end |=> result_r == $past(afe_result))
    else $error("results not captured");

  a_read_x_high: assert property (@(posedge mclk) disable iff (!nrst)
    reg_rd && reg_addr == `ADDR_X_HIGH |=> reg_rvalid && reg_rdata == $past(result_r.x[15:8]))
    else $error("x high byte wrong");

  a_read_n_low: assert property (@(posedge mclk) disable iff (!nrst)
    reg_rd && reg_addr == `ADDR_N_LOW |=> reg_rvalid && reg_rdata == $past(result_r.n[7:0]))
    else $error("n low byte wrong");

  a_integ_length: assert property (@(posedge mclk) disable iff (!nrst)
    integ_end |-> phase_cyc_r + 32'h0000_0001 == 32'(phase_steps_r) * 32'(UNIT_CYC))
    else $error("integration length wrong");

  a_bank_select: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && reg_addr == `ADDR_BANK_SELECT |=> bank_mode == $past(reg_wdata[`BIT_BANK]))
    else $error("bank select not applied");

endmodule
`default_nettype wire

// ### tb/host_model.sv
/*
  Host side of the register port: write, read and 16-bit pair reads.
  Assumes it drives the register port of the bank on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "color_acq_params.svh"
module host_model (
  input  wire logic       mclk,       // system clock
  output logic      [7:0] reg_addr,   // register offset
  output logic      [7:0] reg_wdata,  // write data
  output logic            reg_wr,     // write strobe
  output logic            reg_rd,     // read strobe
  input  wire logic [7:0] reg_rdata,  // read data
  input  wire logic       reg_rvalid  // read data valid
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // ****************************************************************
  // bus cycles
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge mclk);
    reg_wr    = 1'b0;
    // released lines do not keep their value
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic wr_ctrl(input logic latch, input logic wait_en, input logic acq_en);
    wr(`ADDR_ACQ_CONTROL, {latch, 3'b000, wait_en, 1'b0, acq_en, 1'b1});
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge mclk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge mclk);
    reg_rd   = 1'b0;
    d        = reg_rdata;
    v        = reg_rvalid;
    reg_addr = ~a;
  endtask

  task automatic rd16(input logic [7:0] lo, output logic [15:0] val, output logic ok);
    logic [7:0] l;
    logic [7:0] h;
    logic       vl;
    logic       vh;
    rd(lo, l, vl);
    rd(lo + 8'h01, h, vh);
    val = {h, l};
    ok  = vl & vh;
  endtask
endmodule
`default_nettype wire

// ### tb/color_sensor_acquisition_regs_tb.sv
/*
  Self-checking bench of the acquisition register bank.
  Assumes the host model in its own file and a short step of 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "color_acq_params.svh"
module color_sensor_acquisition_regs_tb;
  import color_acq_pkg::*;
  localparam int UNIT = 4;
  logic        mclk;
  logic        nrst;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  result_set_s afe_result;
  logic        bank_mode;
  logic        power_on;
  logic        integrating;
  logic        acq_done;
  int          miscompares;
  int          cmp_count;
  int          cycles;
  localparam result_set_s SET_A = '{n: 16'h1234, y: 16'h5678, z: 16'h9abc, x: 16'hdef0};
  localparam result_set_s SET_B = '{n: 16'h0f1e, y: 16'h2d3c, z: 16'h4b5a, x: 16'h6978};

  color_sensor_acquisition_regs #(.UNIT_CYC(UNIT)) i_color_sensor_acquisition_regs (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .afe_result(afe_result), .bank_mode(bank_mode), .power_on(power_on),
    .integrating(integrating), .acq_done(acq_done));

  host_model i_host_model (
    .mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // ****************************************************************
  // checking helpers
  // ****************************************************************
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    i_host_model.rd(a, d, v);
    check(v, 1'b1);
    check(d, exp);
  endtask

  task automatic pairs_chk(input result_set_s s);
    logic [7:0]  lo [4] = '{`ADDR_N_LOW, `ADDR_Y_LOW, `ADDR_Z_LOW, `ADDR_X_LOW};
    logic [15:0] v;
    logic        ok;
    for (int i = 0; i < 4; i++) begin
      i_host_model.rd16(lo[i], v, ok);
      check(ok, 1'b1);
      check(v, s[63-16*i -: 16]);
    end
  endtask

  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (acq_done !== 1'b1 && n < 2000);
    check(n < 2000, 1'b1);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rchk(`ADDR_INTEG_TIME, 8'hff);
    rchk(`ADDR_PAUSE_TIME, 8'hff);
    rchk(`ADDR_ACQ_CONTROL, 8'h00);
    rchk(`ADDR_BANK_SELECT, 8'h00);
    rchk(8'h10, 8'h00);
    check(integrating, 1'b0);
    check(power_on, 1'b0);
    check(bank_mode, 1'b0);
    pairs_chk('0);
  endtask

  task automatic t_regs();
    i_host_model.wr(`ADDR_PAUSE_TIME, 8'h55);
    rchk(`ADDR_PAUSE_TIME, 8'h55);
    i_host_model.wr(`ADDR_BANK_SELECT, 8'hff);
    rchk(`ADDR_BANK_SELECT, 8'h80);
    check(bank_mode, 1'b1);
    i_host_model.wr(`ADDR_BANK_SELECT, 8'h00);
    check(bank_mode, 1'b0);
    i_host_model.wr(`ADDR_N_LOW, 8'haa);
    i_host_model.wr(8'h10, 8'h33);
    rchk(`ADDR_N_LOW, 8'h00);
    rchk(8'h10, 8'h00);
  endtask

  task automatic t_timing();
    int n;
    i_host_model.wr(`ADDR_INTEG_TIME, 8'hfe);
    i_host_model.wr(`ADDR_PAUSE_TIME, 8'hfd);
    i_host_model.wr_ctrl(1'b0, 1'b0, 1'b1);
    check(power_on, 1'b1);
    wait_done(n);
    wait_done(n);
    check(16'(n), 16'(2 * UNIT));
    @(negedge mclk);
    check(integrating, 1'b1);
    i_host_model.wr_ctrl(1'b0, 1'b1, 1'b1);
    wait_done(n);
    wait_done(n);
    check(16'(n), 16'(5 * UNIT));
    wait_done(n);
    @(negedge mclk);
    check(integrating, 1'b0);
  endtask

  task automatic t_latch();
    int  n;
    logic seen;
    // results hold set b once latched, so only a real capture shows set a
    afe_result = SET_B;
    i_host_model.wr_ctrl(1'b1, 1'b0, 1'b1);
    afe_result = SET_A;
    wait_done(n);
    wait_done(n);
    i_host_model.wr_ctrl(1'b1, 1'b0, 1'b0);
    afe_result = SET_B;
    pairs_chk(SET_A);
    seen = 1'b0;
    repeat (20) begin
      @(negedge mclk);
      seen = seen | acq_done | integrating;
    end
    check(seen, 1'b0);
    i_host_model.wr_ctrl(1'b0, 1'b0, 1'b0);
    pairs_chk(SET_B);
  endtask

  // ****************************************************************
  // clock, reset, watchdog and main sequence
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    miscompares = 0;
    cmp_count   = 0;
    cycles      = 0;
    nrst        = 1'b0;
    afe_result  = '0;
    repeat (20) @(negedge mclk);
    nrst = 1'b1;
    t_reset();
    t_regs();
    t_timing();
    t_latch();
    summarize();
  end
endmodule
`default_nettype wire
